// >>> core/hvc_consts.vh
`ifndef HVC_CONSTS_VH
`define HVC_CONSTS_VH

// register indices, byte address is four times the index
`define HVC_IDX_CTRL      8'h50
`define HVC_IDX_RATE      8'h51
`define HVC_IDX_TXF       8'h52
`define HVC_IDX_TXS       8'h53
`define HVC_IDX_RXF       8'h54
`define HVC_IDX_RXS       8'h55
`define HVC_IDX_XTRA      8'h56

// reset values
`define HVC_CTRL_RST      2'h0
`define HVC_RATE_RST      8'h00
`define HVC_XTRA_RST      1'b1

// link timing
`define HVC_CLK_HZ        100000000
`define HVC_BAUD          115200
`define HVC_FRAME_BITS    10
`define HVC_FRAME_CYC     ((`HVC_CLK_HZ / `HVC_BAUD) * `HVC_FRAME_BITS)

// command decoding
`define HVC_OGF_VENDOR    6'h3f
`define HVC_OCF_READ      10'h001
`define HVC_OCF_WRITE     10'h002
`define HVC_OCF_SETADDR   10'h003
`define HVC_FIXED_TYPE    8'h08
`define HVC_ST_OK         8'h00
`define HVC_ST_FAIL       8'h01
`define HVC_WR_HDR        8'h06
`define HVC_RD_PLEN       8'h09
`define HVC_SA_PLEN       8'h12

// sequencer register space
`define HVC_SEQ_DEPTH     8
`define HVC_SEQ_RADIO     3'h0
`define HVC_SEQ_CTLTX     3'h1
`define HVC_SEQ_CTLRX     3'h2
`define HVC_SEQ_STAT      3'h3
`define HVC_SEQ_VOICE     3'h4
`define HVC_VOICE_MAX     8'h01

// fifos
`define HVC_TXF_DEPTH     4
`define HVC_RXF_DEPTH     8
`define HVC_RTS_SET       4'h6
`define HVC_RTS_LOW       4'h2

`endif

// >>> core/hvc_byte_pacer.v
`timescale 1ns/100ps
// moves one byte per character time divided by rate + 1 from the host queue to the parser
module hvc_byte_pacer #(
    parameter FRAME_CYCLES = 8680
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // source queue
    input  wire        src_vld,
    input  wire [7:0]  src_byte,
    output wire        src_take,
    // flow control and rate
    input  wire        cts,
    input  wire [7:0]  rate,
    // parser side
    output reg         out_vld,
    output reg  [7:0]  out_byte
);
    localparam [15:0] FRAME = FRAME_CYCLES[15:0];
    reg        busy_q;
    reg [15:0] cnt_q;
    wire [15:0] step = {8'h00, rate} + 16'h0001;

    assign src_take = src_vld & ~busy_q & ~cts;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q   <= 1'b0;
            cnt_q    <= 16'h0000;
            out_vld  <= 1'b0;
            out_byte <= 8'h00;
        end else begin
            out_vld <= 1'b0;
            if (src_take) begin
                busy_q   <= 1'b1;
                cnt_q    <= FRAME;
                out_byte <= src_byte;
            end else if (busy_q) begin
                if (cnt_q <= step) begin
                    busy_q  <= 1'b0;
                    out_vld <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - step;
                end
            end
        end
    end
endmodule

// >>> core/hvc_command_port.v
`timescale 1ns/100ps
`include "hvc_consts.vh"
module hvc_command_port #(
    parameter FRAME_CYCLES = `HVC_FRAME_CYC
) (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // radio
    output reg         radio_tx_data,
    output reg         radio_tx_en,
    output reg         radio_rx_en,
    input  wire        radio_rx_data,
    input  wire        radio_sync_detect,
    // radio serial control port
    output reg         ctl_clk,
    output reg         ctl_data_out,
    input  wire        ctl_data_in,
    output reg         ctl_sel_n,
    // status
    output reg         link_rts,
    output reg  [47:0] device_address
);
    localparam [5:0] S_OP0 = 6'h01, S_OP1 = 6'h02, S_PLEN = 6'h04,
                     S_BODY = 6'h08, S_DONE = 6'h10, S_RESP = 6'h20;

    // register file
    reg  [1:0]  ctrl_q;
    reg  [7:0]  rate_q;
    reg         xtra_q;
    wire [7:0]  idx = paddr[9:2];
    wire        acc = psel & penable & pready;
    wire        hit = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                      (idx >= `HVC_IDX_CTRL) && (idx <= `HVC_IDX_XTRA);

    // host to sequencer queue
    reg  [7:0]  txf [0:`HVC_TXF_DEPTH-1];
    reg  [2:0]  txw_q, txr_q;
    wire [2:0]  txn = txw_q - txr_q;
    wire        tx_full = (txn == 3'd4);
    wire        tx_take;
    wire        tx_push = acc & pwrite & (idx == `HVC_IDX_TXF) & ~tx_full;

    // sequencer to host queue
    reg  [7:0]  rxf [0:`HVC_RXF_DEPTH-1];
    reg  [3:0]  rxw_q, rxr_q;
    wire [3:0]  rxn = rxw_q - rxr_q;
    wire        rx_empty = (rxn == 4'd0);
    wire        rx_full = (rxn == 4'd8);
    wire        rx_pop = acc & ~pwrite & (idx == `HVC_IDX_RXF) & ~rx_empty;
    wire        rx_push;

    // parser
    reg  [5:0]  st_q;
    reg  [15:0] op_q;
    reg  [7:0]  plen_q, bi_q, ri_q, wlen_q;
    reg  [31:0] addr_q, rlen_q;
    reg         ok_q;
    reg  [47:0] bda_q;
    reg  [7:0]  seq_q [0:`HVC_SEQ_DEPTH-1];
    reg         ctl_go_q;
    reg  [7:0]  ctl_rx_q;
    wire        in_vld;
    wire [7:0]  in_byte;

    wire        vend = (op_q[15:10] == `HVC_OGF_VENDOR);
    wire        is_rd = vend & (op_q[9:0] == `HVC_OCF_READ);
    wire        is_wr = vend & (op_q[9:0] == `HVC_OCF_WRITE);
    wire        is_sa = vend & (op_q[9:0] == `HVC_OCF_SETADDR);
    wire        last = (bi_q == plen_q - 8'h01);
    // hold back the next byte on the edge that ends a packet
    wire        cts = ~(st_q[0] | st_q[1] | st_q[2] | st_q[3]) |
                      (in_vld & (st_q[2] ? in_byte == 8'h00 : st_q[3] & last));
    wire [2:0]  wi = addr_q[2:0] + bi_q[2:0] - 3'd6;
    wire [31:0] lim = `HVC_SEQ_DEPTH;
    wire [31:0] a_in = {addr_q[23:0], in_byte};
    wire        rd_good = ok_q && plen_q == `HVC_RD_PLEN &&
                          addr_q < lim && rlen_q <= lim - addr_q;
    wire [7:0]  rtot = (is_rd & ok_q) ? rlen_q[7:0] + 8'h02 :
                       (is_rd ? 8'h02 : 8'h01);
    wire [2:0]  ri3 = addr_q[2:0] + ri_q[2:0] - 3'd2;
    reg  [7:0]  rbyte;
    integer     k;

    always @* begin
        case (ri3)
            `HVC_SEQ_CTLRX: rbyte = ctl_rx_q;
            `HVC_SEQ_STAT:  rbyte = {6'h00, radio_sync_detect,
                                     radio_rx_data};
            default:        rbyte = seq_q[ri3];
        endcase
        if (ri_q == 8'h00)
            rbyte = ok_q ? `HVC_ST_OK : `HVC_ST_FAIL;
        else if (ri_q == 8'h01)
            rbyte = ok_q ? rlen_q[7:0] : 8'h00;
    end

    assign rx_push = st_q[5] & ~rx_full & ~link_rts;

    hvc_byte_pacer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_pacer (
        .clk      (pclk),
        .rst_n    (presetn),
        .src_vld  (txn != 3'd0),
        .src_byte (txf[txr_q[1:0]]),
        .src_take (tx_take),
        .cts      (cts),
        .rate     (rate_q),
        .out_vld  (in_vld),
        .out_byte (in_byte)
    );

    // apb slave: no wait state, answer registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            ctrl_q  <= `HVC_CTRL_RST;
            rate_q  <= `HVC_RATE_RST;
            xtra_q  <= `HVC_XTRA_RST;
            txw_q   <= 3'd0;
            rxr_q   <= 4'd0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata  <= 32'h0000_0000;
            if (psel & ~penable & hit & ~pwrite) begin
                case (idx)
                    `HVC_IDX_CTRL: prdata[7:0] <= {4'h0, ctrl_q, 2'b11};
                    `HVC_IDX_RATE: prdata[7:0] <= rate_q;
                    `HVC_IDX_TXS:  prdata[7:0] <= {6'h00, tx_full,
                                                   txn == 3'd0};
                    `HVC_IDX_RXF:  prdata[7:0] <= rxf[rxr_q[2:0]];
                    `HVC_IDX_RXS:  prdata[7:0] <= {5'h00, link_rts,
                                                   rx_full, ~rx_empty};
                    `HVC_IDX_XTRA: prdata[7:0] <= {7'h00, xtra_q};
                    default:       prdata[7:0] <= 8'h00;
                endcase
            end
            if (acc & pwrite & hit) begin
                case (idx)
                    `HVC_IDX_CTRL: ctrl_q <= pwdata[3:2];
                    `HVC_IDX_RATE: rate_q <= pwdata[7:0];
                    `HVC_IDX_XTRA: xtra_q <= pwdata[0];
                    default:       ctrl_q <= ctrl_q;
                endcase
            end
            if (tx_push) begin
                txf[txw_q[1:0]] <= pwdata[7:0];
                txw_q <= txw_q + 3'd1;
            end
            if (rx_pop)
                rxr_q <= rxr_q + 4'd1;
        end
    end

    // receive-side flow control
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_rts <= 1'b0;
        end else if (rxn >= `HVC_RTS_SET) begin
            link_rts <= 1'b1;
        end else if (xtra_q ? rx_empty : rxn <= `HVC_RTS_LOW) begin
            link_rts <= 1'b0;
        end
    end

    // command interpreter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= S_OP0;
            op_q     <= 16'h0000;
            plen_q   <= 8'h00;
            bi_q     <= 8'h00;
            ri_q     <= 8'h00;
            wlen_q   <= 8'h00;
            addr_q   <= 32'h0000_0000;
            rlen_q   <= 32'h0000_0000;
            ok_q     <= 1'b0;
            bda_q    <= 48'h0000_0000_0000;
            device_address <= 48'h0000_0000_0000;
            txr_q    <= 3'd0;
            rxw_q    <= 4'd0;
            ctl_go_q <= 1'b0;
            for (k = 0; k < `HVC_SEQ_DEPTH; k = k + 1)
                seq_q[k] <= 8'h00;
        end else begin
            ctl_go_q <= 1'b0;
            if (tx_take)
                txr_q <= txr_q + 3'd1;
            case (st_q)
                S_OP0: if (in_vld) begin
                    op_q[7:0] <= in_byte;
                    st_q <= S_OP1;
                end
                S_OP1: if (in_vld) begin
                    op_q[15:8] <= in_byte;
                    st_q <= S_PLEN;
                end
                S_PLEN: if (in_vld) begin
                    plen_q <= in_byte;
                    bi_q   <= 8'h00;
                    ok_q   <= 1'b1;
                    rlen_q <= 32'h0000_0000;
                    st_q   <= (in_byte == 8'h00) ? S_DONE : S_BODY;
                end
                S_BODY: if (in_vld) begin
                    bi_q <= bi_q + 8'h01;
                    if (is_rd | is_wr) begin
                        if (bi_q < 8'h04)
                            addr_q <= a_in;
                        else if (bi_q == 8'h04 &&
                                 in_byte != `HVC_FIXED_TYPE)
                            ok_q <= 1'b0;
                        else if (is_rd && bi_q < 8'h09)
                            rlen_q <= {rlen_q[23:0], in_byte};
                        else if (is_wr && bi_q == 8'h05) begin
                            wlen_q <= in_byte;
                            if (addr_q >= lim ||
                                {24'h0, in_byte} > lim - addr_q ||
                                plen_q != `HVC_WR_HDR + in_byte)
                                ok_q <= 1'b0;
                        end else if (is_wr && ok_q &&
                                     bi_q < `HVC_WR_HDR + wlen_q) begin
                            if (wi == `HVC_SEQ_VOICE &&
                                in_byte > `HVC_VOICE_MAX)
                                ok_q <= 1'b0;
                            else if (wi != `HVC_SEQ_CTLRX &&
                                     wi != `HVC_SEQ_STAT) begin
                                seq_q[wi] <= in_byte;
                                ctl_go_q <= (wi == `HVC_SEQ_CTLTX);
                            end
                        end
                    end else if (is_sa) begin
                        if (bi_q >= 8'h01 && bi_q <= 8'h06)
                            bda_q <= {in_byte, bda_q[47:8]};
                        else if (in_byte != 8'h00)
                            ok_q <= 1'b0;
                    end else begin
                        ok_q <= 1'b0;
                    end
                    if (last)
                        st_q <= S_DONE;
                end
                S_DONE: begin
                    ri_q <= 8'h00;
                    if (is_rd)
                        ok_q <= rd_good;
                    else if (is_sa && ok_q && plen_q == `HVC_SA_PLEN)
                        device_address <= bda_q;
                    else if (is_sa || !(is_wr && plen_q != 8'h00))
                        ok_q <= 1'b0;
                    st_q <= S_RESP;
                end
                S_RESP: if (rx_push) begin
                    rxf[rxw_q[2:0]] <= rbyte;
                    rxw_q <= rxw_q + 4'd1;
                    ri_q  <= ri_q + 8'h01;
                    if (ri_q == rtot - 8'h01)
                        st_q <= S_OP0;
                end
                default: st_q <= S_OP0;
            endcase
        end
    end

    // radio pins and serial control port master
    reg [3:0] ctl_cnt_q;
    reg [7:0] ctl_sh_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            radio_tx_data <= 1'b0;
            radio_tx_en   <= 1'b0;
            radio_rx_en   <= 1'b0;
            ctl_clk       <= 1'b0;
            ctl_data_out  <= 1'b0;
            ctl_sel_n     <= 1'b1;
            ctl_cnt_q     <= 4'h0;
            ctl_sh_q      <= 8'h00;
            ctl_rx_q      <= 8'h00;
        end else begin
            radio_tx_en   <= seq_q[`HVC_SEQ_RADIO][0];
            radio_rx_en   <= seq_q[`HVC_SEQ_RADIO][1];
            radio_tx_data <= seq_q[`HVC_SEQ_RADIO][2];
            if (ctl_go_q && ctl_cnt_q == 4'h0) begin
                ctl_sel_n    <= 1'b0;
                ctl_cnt_q    <= 4'h8;
                ctl_sh_q     <= seq_q[`HVC_SEQ_CTLTX];
                ctl_data_out <= seq_q[`HVC_SEQ_CTLTX][7];
            end else if (ctl_cnt_q != 4'h0) begin
                ctl_clk <= ~ctl_clk;
                if (!ctl_clk) begin
                    ctl_rx_q <= {ctl_rx_q[6:0], ctl_data_in};
                end else begin
                    ctl_sh_q     <= {ctl_sh_q[6:0], 1'b0};
                    ctl_data_out <= ctl_sh_q[6];
                    ctl_cnt_q    <= ctl_cnt_q - 4'h1;
                    if (ctl_cnt_q == 4'h1)
                        ctl_sel_n <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> verif/hvc_checker_assertions.sv
`timescale 1ns/100ps
module hvc_checker #(
    parameter FRAME_CYCLES = 20
) (
    // apb
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // radio
    input wire        radio_tx_data,
    input wire        radio_tx_en,
    input wire        radio_rx_en,
    input wire        radio_rx_data,
    input wire        radio_sync_detect,
    input wire        ctl_clk,
    input wire        ctl_data_out,
    input wire        ctl_data_in,
    input wire        ctl_sel_n,
    // status
    input wire        link_rts,
    input wire [47:0] device_address
);
    wire rx_pop = pready && !pwrite && paddr == 12'h150;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_one; psel && !penable |=> pready; endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("no answer after setup");
    property p_ready_cause; pready |-> $past(psel && !penable); endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("answer without setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("answer longer than one cycle");
    property p_err_pair; pslverr |-> pready; endproperty
    a_err_pair: assert property (p_err_pair)
        else $error("error flag without answer");
    property p_byte_wide; prdata[31:8] == 24'h0; endproperty
    a_byte_wide: assert property (p_byte_wide)
        else $error("read data wider than a byte");
    property p_ctrl_bits;
        pready && !pwrite && paddr == 12'h140 |-> prdata[1:0] == 2'b11;
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits)
        else $error("flow control bit not set");
    property p_unmapped;
        pready && (paddr < 12'h140 || paddr > 12'h158) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access without error");
    property p_rts_fall;
        $fell(link_rts) |-> $past(rx_pop) || $past(rx_pop, 2);
    endproperty
    a_rts_fall: assert property (p_rts_fall)
        else $error("rts released without a pop");
    property p_sel_idle; ctl_sel_n |-> !ctl_clk; endproperty
    a_sel_idle: assert property (p_sel_idle)
        else $error("serial clock active while idle");
    property p_clk_half; $rose(ctl_clk) |=> $fell(ctl_clk); endproperty
    a_clk_half: assert property (p_clk_half)
        else $error("serial clock high too long");
endmodule
bind hvc_command_port hvc_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .radio_tx_data(radio_tx_data),
    .radio_tx_en(radio_tx_en), .radio_rx_en(radio_rx_en),
    .radio_rx_data(radio_rx_data), .radio_sync_detect(radio_sync_detect),
    .ctl_clk(ctl_clk), .ctl_data_out(ctl_data_out),
    .ctl_data_in(ctl_data_in), .ctl_sel_n(ctl_sel_n),
    .link_rts(link_rts), .device_address(device_address)
);

// >>> verif/hvc_radio_model.sv
`timescale 1ns/100ps
module hvc_radio_model #(
    parameter [7:0] REPLY = 8'ha6
) (
    // serial control port
    input  wire       ctl_clk,
    input  wire       ctl_data_out,
    input  wire       ctl_sel_n,
    output wire       ctl_data_in,
    // last byte shifted in
    output reg  [7:0] got_byte
);
    reg [7:0] tx_sr;
    reg       last;
    initial begin
        tx_sr = REPLY;
        last = 1'b0;
        got_byte = 8'h00;
    end
    // mode 0: first bit out at select, sample on rise, shift on fall
    always @(negedge ctl_sel_n) tx_sr = REPLY;
    always @(posedge ctl_clk) begin
        if (!ctl_sel_n) begin
            got_byte = {got_byte[6:0], ctl_data_out};
            last = tx_sr[7];
        end
    end
    always @(negedge ctl_clk) begin
        if (!ctl_sel_n) tx_sr = {tx_sr[6:0], 1'b0};
    end
    // released line shows the inverse of the last bit
    assign ctl_data_in = ctl_sel_n ? ~last : tx_sr[7];
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam [7:0] REPLY = 8'ha6;
    reg         pclk, presetn, psel, penable, pwrite, chk;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, radio_tx_data, radio_tx_en, radio_rx_en;
    reg         radio_rx_data, radio_sync_detect;
    wire        ctl_clk, ctl_data_out, ctl_data_in, ctl_sel_n, link_rts;
    wire [47:0] device_address;
    wire [7:0]  got_byte;
    reg  [47:0] exp_q[$];
    reg  [47:0] aexp;
    reg  [7:0]  cmd[$];
    reg  [7:0]  dat[0:2];
    reg  [7:0]  rv;
    integer     mismatches, total_checks, n, k, i, j;
    hvc_command_port #(.FRAME_CYCLES(20)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .radio_tx_data(radio_tx_data),
        .radio_tx_en(radio_tx_en), .radio_rx_en(radio_rx_en),
        .radio_rx_data(radio_rx_data), .radio_sync_detect(radio_sync_detect),
        .ctl_clk(ctl_clk), .ctl_data_out(ctl_data_out),
        .ctl_data_in(ctl_data_in), .ctl_sel_n(ctl_sel_n),
        .link_rts(link_rts), .device_address(device_address)
    );
    hvc_radio_model #(.REPLY(REPLY)) u_radio (
        .ctl_clk(ctl_clk), .ctl_data_out(ctl_data_out),
        .ctl_sel_n(ctl_sel_n), .ctl_data_in(ctl_data_in),
        .got_byte(got_byte)
    );
    always #5 pclk = ~pclk;
    function [47:0] ok8(input [7:0] b);
        ok8 = {40'h0, b};
    endfunction
    task check(input [47:0] seen, input [47:0] want);
        begin
            total_checks = total_checks + 1;
            if (seen !== want) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: %h expected %h",
                         $time, seen, want);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (mismatches == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task apb(input w, input [11:0] a, input [7:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h0, d};
            @(posedge pclk);
            penable <= 1'b1;
            do begin
                @(posedge pclk);
            end while (pready !== 1'b1);
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd_chk(input [11:0] a, input [47:0] want);
        begin
            exp_q.push_back(want);
            @(posedge pclk);
            chk <= 1'b1;
            apb(1'b0, a, 8'h00);
            chk <= 1'b0;
        end
    endtask
    // queued expectations meet read answers here
    always @(posedge pclk) begin
        if (chk && psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0)
                check(48'hffff, 48'h0);
            else
                check({15'h0, pslverr, prdata}, exp_q.pop_front());
        end
    end
    task get(input [7:0] b);
        begin
            k = 0;
            rd = 32'h0;
            while (rd[0] !== 1'b1 && k < 500) begin
                apb(1'b0, 12'h154, 8'h00);
                k = k + 1;
            end
            if (rd[0] !== 1'b1)
                mismatches = mismatches + 1;
            rd_chk(12'h150, ok8(b));
        end
    endtask
    task send;
        while (cmd.size() > 0) begin
            rd = 32'h2;
            while (rd[1] !== 1'b0) apb(1'b0, 12'h14c, 8'h00);
            apb(1'b1, 12'h148, cmd.pop_front());
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] fx, input [7:0] c);
        begin
            cmd = {8'h02, 8'hfc, 8'h06 + c, 8'h00, 8'h00, 8'h00, a, fx, c};
            for (i = 0; i < c; i = i + 1) cmd.push_back(dat[i]);
            send();
        end
    endtask
    task pins(input [2:0] e);
        check({45'h0, radio_tx_data, radio_rx_en, radio_tx_en}, e);
    endtask
    initial begin
        repeat (50000) @(posedge pclk);
        mismatches = mismatches + 1;
        report_and_stop();
    end
    initial begin
        {pclk, psel, penable, pwrite, chk} = 5'h0;
        {paddr, pwdata, presetn, mismatches, total_checks} = 0;
        n = $urandom(32'h7acb);
        radio_rx_data = $urandom;
        radio_sync_detect = $urandom;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(12'h140, ok8(8'h03));
        rd_chk(12'h144, ok8(8'h00));
        rd_chk(12'h14c, ok8(8'h01));
        rd_chk(12'h154, ok8(8'h00));
        rd_chk(12'h158, ok8(8'h01));
        rd_chk(12'h15c, {15'h0, 1'b1, 32'h0});
        apb(1'b1, 12'h140, 8'h0c);
        rd_chk(12'h140, ok8(8'h0f));
        rv = $urandom;
        dat[0] = {5'h0, rv[2:0]};
        wr_reg(8'h00, 8'h08, 8'h01);
        get(8'h00);
        pins(rv[2:0]);
        dat[0] = ~dat[0];
        wr_reg(8'h00, 8'h07, 8'h01);
        get(8'h01);
        pins(rv[2:0]);
        for (j = 2; j > 0; j = j - 1) begin
            dat[0] = j;
            wr_reg(8'h04, 8'h08, 8'h01);
            get({7'h0, j[1]});
        end
        rv = $urandom;
        dat[0] = rv;
        wr_reg(8'h01, 8'h08, 8'h01);
        get(8'h00);
        for (i = 0; i < 3; i = i + 1) dat[i] = $urandom;
        wr_reg(8'h05, 8'h08, 8'h03);
        get(8'h00);
        check(got_byte, rv);
        cmd = {8'h01, 8'hfc, 8'h09, 8'h00, 8'h00, 8'h00, 8'h02, 8'h08};
        cmd = {cmd, 8'h00, 8'h00, 8'h00, 8'h06};
        send();
        k = 0;
        while (link_rts !== 1'b1 && k < 3000) begin
            @(posedge pclk);
            k = k + 1;
        end
        rd_chk(12'h154, ok8(8'h05));
        get(8'h00);
        get(8'h06);
        get(REPLY);
        get({6'h0, radio_sync_detect, radio_rx_data});
        get(8'h01);
        for (i = 0; i < 3; i = i + 1) get(dat[i]);
        aexp = 48'h0;
        for (j = 0; j < 2; j = j + 1) begin
            cmd = {8'h03, 8'hfc, 8'h12, 8'h00};
            for (i = 0; i < 17; i = i + 1) begin
                rv = $urandom;
                cmd.push_back(i < 6 ? rv : {7'h0, i == 16 && j == 1});
                if (i < 6 && j == 0) aexp[8*i +: 8] = rv;
            end
            send();
            get({7'h0, j[0]});
            check(device_address, aexp);
        end
        report_and_stop();
    end
endmodule
